/* pcc_config_regs.sv */
// read-only processor capability register bank
//
// Contract
// - registers read-only; writes change nothing
// - fixed fields plus build-time implementation constants
// - bits 31:24 hold processor type code
// - bits 19:16 hold implementation revision
// - bit 0 reads 0: no RMW
`timescale 1ns/10ps
module pcc_config_regs
    import pcc_pkg::*;
#(
    parameter logic [7:0]  PROC_ID  = PCC_PROC_ID_DEF,
    parameter logic [3:0]  PROC_REV = PCC_PROC_REV_DEF,
    parameter logic [31:0] WORD1    = PCC_WORD1_DEF
)(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [31:0] rdData,
    output logic             rdValid,
    output logic             wrIgnored
);

    pcc_req_type req;
    logic [31:0] romWord;
    logic        romHit;
    logic [31:0] next_rdData;
    logic        next_rdValid;
    logic        next_wrIgnored;

    // reference word built field by field, apart from the rom helper
    function automatic logic [31:0] pcc_word0_ref(
        input logic [7:0] procId,
        input logic [3:0] procRev
    );
        return {procId, PCC_RSVD_VAL, procRev, PCC_ARCH_TYPE_VAL,
                PCC_ARCH_REV_VAL, PCC_MMU_SHARED, PCC_FPU_VAL,
                PCC_JEXT_VAL, PCC_PERF_VAL, PCC_DEBUG_VAL,
                PCC_SIMD_VAL, PCC_DSP_VAL, PCC_RMW_VAL};
    endfunction : pcc_word0_ref

    localparam logic [31:0] WORD0_REF = pcc_word0_ref(PROC_ID, PROC_REV);

    assign req = '{addr: addr, rdStrobe: rdStrobe, wrStrobe: wrStrobe};

    pcc_word_rom #(
        .PROC_ID  (PROC_ID),
        .PROC_REV (PROC_REV),
        .WORD1    (WORD1)
    ) pcc_word_rom_i (
        .addr (req.addr),
        .word (romWord),
        .hit  (romHit)
    );

    // write data is never stored; it only flags the attempt
    always_comb
    begin
        next_rdData    = PCC_RDATA_ZERO;
        next_rdValid   = 1'b0;
        next_wrIgnored = 1'b0;
        if (req.rdStrobe)
        begin
            next_rdData  = romHit ? romWord : PCC_RDATA_ZERO;
            next_rdValid = 1'b1;
        end
        if (req.wrStrobe)
        begin
            next_wrIgnored = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdData    <= PCC_RDATA_ZERO;
            rdValid   <= 1'b0;
            wrIgnored <= 1'b0;
        end
        else if (clkEn)
        begin
            rdData    <= next_rdData;
            rdValid   <= next_rdValid;
            wrIgnored <= next_wrIgnored;
        end
    end

    property p_read_word0;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD0) |=>
            rdValid && rdData[31:PCC_POS_PROC_ID] == PROC_ID;
    endproperty
    a_read_word0: assert property (p_read_word0)
        else $error("processor type code wrong");

    property p_rev;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD0) |=>
            rdData[PCC_POS_RSVD-1:PCC_POS_PROC_REV] == PROC_REV
            && rdData[PCC_POS_PROC_ID-1:PCC_POS_RSVD] == PCC_RSVD_VAL;
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision or reserved field wrong");

    property p_arch;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD0) |=>
            rdData[PCC_POS_PROC_REV-1:PCC_POS_ARCH_TYPE] == PCC_ARCH_TYPE_VAL;
    endproperty
    a_arch: assert property (p_arch)
        else $error("architecture type not 1");

    property p_rmw;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD0) |=> !rdData[PCC_POS_RMW];
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("rmw bit set");

    property p_flags;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD0) |=>
            rdData[PCC_POS_ARCH_TYPE-1:PCC_POS_RMW]
            == WORD0_REF[PCC_POS_ARCH_TYPE-1:PCC_POS_RMW];
    endproperty
    a_flags: assert property (p_flags)
        else $error("low capability fields wrong");

    sequence s_write_then_read;
        (clkEn && wrStrobe && addr == PCC_ADDR_WORD0)
        ##1 (clkEn && rdStrobe && addr == PCC_ADDR_WORD0);
    endsequence

    property p_write_no_effect;
        @(posedge clk_sys) disable iff (!rstn)
        s_write_then_read |=> rdData == 32'(pcc_make_word0(PROC_ID, PROC_REV));
    endproperty
    a_write_no_effect: assert property (p_write_no_effect)
        else $error("write changed capability word");

    property p_word1;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe && addr == PCC_ADDR_WORD1) |=> rdData == WORD1;
    endproperty
    a_word1: assert property (p_word1)
        else $error("second word not build constant");

    property p_valid_one;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && rdStrobe) ##1 (clkEn && !rdStrobe) |=> !rdValid;
    endproperty
    a_valid_one: assert property (p_valid_one)
        else $error("read valid held too long");

    // read and write takes shared by the checks below
    sequence s_take_read;
        clkEn && rdStrobe;
    endsequence

    sequence s_take_write;
        clkEn && wrStrobe;
    endsequence

    sequence s_take_word0_read;
        clkEn && rdStrobe && addr == PCC_ADDR_WORD0;
    endsequence

    sequence s_take_word1_read;
        clkEn && rdStrobe && addr == PCC_ADDR_WORD1;
    endsequence

    sequence s_take_unmapped_read;
        clkEn && rdStrobe && addr != PCC_ADDR_WORD0
        && addr != PCC_ADDR_WORD1;
    endsequence

    // every taken read answers on the next edge
    property p_read_valid;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_read |=> rdValid;
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("read not answered");

    // an enabled cycle without a read drops valid and data back to zero
    property p_idle_no_valid;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && !rdStrobe) |=> !rdValid;
    endproperty
    a_idle_no_valid: assert property (p_idle_no_valid)
        else $error("read valid without a read");

    property p_idle_data_zero;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && !rdStrobe) |=> rdData == PCC_RDATA_ZERO;
    endproperty
    a_idle_data_zero: assert property (p_idle_data_zero)
        else $error("read data not zero between reads");

    // holes in the map read as zero but still answer
    property p_unmapped_zero;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_unmapped_read |=> rdValid && rdData == PCC_RDATA_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    // a write only raises the flag; no data is stored
    property p_write_flag;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_write |=> wrIgnored && !rdValid;
    endproperty
    a_write_flag: assert property (p_write_flag)
        else $error("write not flagged as ignored");

    property p_idle_no_flag;
        @(posedge clk_sys) disable iff (!rstn)
        (clkEn && !wrStrobe) |=> !wrIgnored;
    endproperty
    a_idle_no_flag: assert property (p_idle_no_flag)
        else $error("ignored flag without a write");

    // word 0 as a whole, then its fields on their own, so a failure names it
    property p_word0_whole;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read |=> rdData == WORD0_REF;
    endproperty
    a_word0_whole: assert property (p_word0_whole)
        else $error("capability word 0 wrong");

    property p_arch_rev;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read |=>
            rdData[PCC_POS_ARCH_TYPE-1:PCC_POS_ARCH_REV] == PCC_ARCH_REV_VAL;
    endproperty
    a_arch_rev: assert property (p_arch_rev)
        else $error("architecture revision not 1");

    property p_mmu_kind;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read |=>
            rdData[PCC_POS_ARCH_REV-1:PCC_POS_MMU_KIND] == PCC_MMU_SHARED;
    endproperty
    a_mmu_kind: assert property (p_mmu_kind)
        else $error("mmu kind not shared table");

    property p_no_fpu;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read |=> rdData[PCC_POS_FPU] == PCC_FPU_VAL;
    endproperty
    a_no_fpu: assert property (p_no_fpu)
        else $error("fpu bit set");

    property p_extensions;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read |=> rdData[PCC_POS_JEXT:PCC_POS_DSP]
            == {PCC_JEXT_VAL, PCC_PERF_VAL, PCC_DEBUG_VAL,
                PCC_SIMD_VAL, PCC_DSP_VAL};
    endproperty
    a_extensions: assert property (p_extensions)
        else $error("extension bits wrong");

    // a pair of reads must answer in order, one word each
    property p_word0_then_word1;
        @(posedge clk_sys) disable iff (!rstn)
        s_take_word0_read ##1 s_take_word1_read |->
            rdData == WORD0_REF ##1 rdData == WORD1;
    endproperty
    a_word0_then_word1: assert property (p_word0_then_word1)
        else $error("back to back reads out of order");

    // a low enable holds every answer, even mid pulse
    property p_freeze_data;
        @(posedge clk_sys) disable iff (!rstn)
        !clkEn |=> $stable(rdData);
    endproperty
    a_freeze_data: assert property (p_freeze_data)
        else $error("read data moved while disabled");

    property p_freeze_flags;
        @(posedge clk_sys) disable iff (!rstn)
        !clkEn |=> $stable(rdValid) && $stable(wrIgnored);
    endproperty
    a_freeze_flags: assert property (p_freeze_flags)
        else $error("pulse outputs moved while disabled");

    // no disable here: the reset values themselves are checked
    property p_reset_quiet;
        @(posedge clk_sys)
        !rstn |-> rdData == PCC_RDATA_ZERO && !rdValid && !wrIgnored;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared in reset");

endmodule : pcc_config_regs

/* pcc_config_regs_tb.sv */
// self-checking bench for the capability register bank
`timescale 1ns/10ps
module pcc_config_regs_tb
    import pcc_pkg::*;
;
    // build-time values, arbitrary
    localparam logic [7:0]  TB_ID  = 8'hC3;
    localparam logic [3:0]  TB_REV = 4'h9;
    localparam logic [31:0] TB_W1  = 32'h1234_5678;

    logic        clk_sys;
    logic        rstn;
    logic        clkEn;
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [31:0] rdData;
    logic        rdValid;
    logic        wrIgnored;
    int          error_cnt;
    int          comparisons;
    int          pick;

    pcc_config_regs #(.PROC_ID(TB_ID), .PROC_REV(TB_REV), .WORD1(TB_W1))
        pcc_config_regs_i (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
        .wrIgnored(wrIgnored));

    function automatic logic [31:0] exp_word(input logic [7:0] a);
        if (a == PCC_ADDR_WORD0)
            return {TB_ID, 4'h0, TB_REV, 3'h1, 3'h1, 3'h2, 1'b0, 5'h1F, 1'b0};
        if (a == PCC_ADDR_WORD1)
            return TB_W1;
        return PCC_RDATA_ZERO;
    endfunction : exp_word

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp32

    task automatic cmp1(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask : cmp1

    task automatic rd(input logic [7:0] a, input logic v);
        @(posedge clk_sys);
        addr     <= a;
        wrData   <= $urandom;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        cmp1(rdValid, v);
        cmp1(wrIgnored, 1'b0);
        cmp32(rdData, v ? exp_word(a) : PCC_RDATA_ZERO);
        @(negedge clk_sys);
        cmp1(rdValid, 1'b0);
        cmp32(rdData, PCC_RDATA_ZERO);
    endtask : rd

    task automatic wr(input logic [7:0] a);
        @(posedge clk_sys);
        addr     <= a;
        wrData   <= $urandom;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
        @(negedge clk_sys);
        cmp1(wrIgnored, 1'b1);
        cmp1(rdValid, 1'b0);
        @(negedge clk_sys);
        cmp1(wrIgnored, 1'b0);
    endtask : wr

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // run needs about 130 cycles; the limit of 10000 cycles lies far above that
    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        {rstn, clkEn, wrStrobe, rdStrobe, addr, wrData} = '0;
        error_cnt   = 0;
        comparisons = 0;
        void'($urandom(32'h68d9));
        repeat (16) @(posedge clk_sys);
        cmp32(rdData, PCC_RDATA_ZERO);
        rstn  <= 1'b1;
        clkEn <= 1'b1;
        rd(PCC_ADDR_WORD0, 1'b1);
        rd(PCC_ADDR_WORD1, 1'b1);
        rd(8'h01, 1'b1);
        rd(8'hFF, 1'b1);
        $display("test fixed reads done");
        // write then read with no gap
        @(posedge clk_sys);
        addr     <= PCC_ADDR_WORD0;
        wrData   <= 32'hFFFF_FFFF;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(negedge clk_sys);
        cmp1(wrIgnored, 1'b1);
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        cmp32(rdData, exp_word(PCC_ADDR_WORD0));
        @(posedge clk_sys);
        addr     <= PCC_ADDR_WORD0;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        addr     <= PCC_ADDR_WORD1;
        @(negedge clk_sys);
        cmp32(rdData, exp_word(PCC_ADDR_WORD0));
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        cmp32(rdData, exp_word(PCC_ADDR_WORD1));
        cmp1(rdValid, 1'b1);
        $display("test back-to-back done");
        repeat (24)
        begin
            pick = $urandom_range(0, 2);
            addr <= addr;
            if ($urandom_range(0, 1) == 1)
                wr(pick == 0 ? PCC_ADDR_WORD0 : 8'($urandom));
            else
                rd(pick == 1 ? PCC_ADDR_WORD1 : 8'($urandom), 1'b1);
        end
        rd(PCC_ADDR_WORD0, 1'b1);
        rd(PCC_ADDR_WORD1, 1'b1);
        $display("test random traffic done");
        clkEn <= 1'b0;
        rd(PCC_ADDR_WORD0, 1'b0);
        clkEn <= 1'b1;
        rd(PCC_ADDR_WORD0, 1'b1);
        $display("test clock enable done");
        // a held answer must survive a low enable, and reset clears it
        @(posedge clk_sys);
        addr     <= PCC_ADDR_WORD0;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        clkEn    <= 1'b0;
        repeat (3)
        begin
            @(negedge clk_sys);
            cmp1(rdValid, 1'b1);
            cmp32(rdData, exp_word(PCC_ADDR_WORD0));
        end
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        cmp1(rdValid, 1'b0);
        cmp32(rdData, PCC_RDATA_ZERO);
        @(posedge clk_sys);
        rstn  <= 1'b1;
        clkEn <= 1'b1;
        rd(PCC_ADDR_WORD0, 1'b1);
        $display("test hold and reset done");
        print_verdict();
    end
endmodule : pcc_config_regs_tb

/* pcc_pkg.sv */
// package: capability word layout, offsets and constants
package pcc_pkg;

    localparam logic [7:0]  PCC_ADDR_WORD0    = 8'h00;
    localparam logic [7:0]  PCC_ADDR_WORD1    = 8'h04;
    localparam logic [31:0] PCC_RDATA_ZERO    = 32'h0000_0000;

    // field positions of capability word 0
    localparam int PCC_POS_PROC_ID   = 24;
    localparam int PCC_POS_RSVD      = 20;
    localparam int PCC_POS_PROC_REV  = 16;
    localparam int PCC_POS_ARCH_TYPE = 13;
    localparam int PCC_POS_ARCH_REV  = 10;
    localparam int PCC_POS_MMU_KIND  = 7;
    localparam int PCC_POS_FPU       = 6;
    localparam int PCC_POS_JEXT      = 5;
    localparam int PCC_POS_PERF      = 4;
    localparam int PCC_POS_DEBUG     = 3;
    localparam int PCC_POS_SIMD      = 2;
    localparam int PCC_POS_DSP       = 1;
    localparam int PCC_POS_RMW       = 0;

    // platform-fixed field values
    localparam logic [3:0] PCC_RSVD_VAL      = 4'h0;
    localparam logic [2:0] PCC_ARCH_TYPE_VAL = 3'h1;
    localparam logic [2:0] PCC_ARCH_REV_VAL  = 3'h1;
    localparam logic [2:0] PCC_MMU_SHARED    = 3'h2;
    localparam logic       PCC_FPU_VAL       = 1'b0;
    localparam logic       PCC_JEXT_VAL      = 1'b1;
    localparam logic       PCC_PERF_VAL      = 1'b1;
    localparam logic       PCC_DEBUG_VAL     = 1'b1;
    localparam logic       PCC_SIMD_VAL      = 1'b1;
    localparam logic       PCC_DSP_VAL       = 1'b1;
    localparam logic       PCC_RMW_VAL       = 1'b0;

    // implementation-chosen defaults; identity values are arbitrary
    localparam logic [7:0]  PCC_PROC_ID_DEF  = 8'h5A;
    localparam logic [3:0]  PCC_PROC_REV_DEF = 4'h3;
    localparam logic [31:0] PCC_WORD1_DEF    = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] procId;
        logic [3:0] reserved;
        logic [3:0] procRev;
        logic [2:0] archType;
        logic [2:0] archRev;
        logic [2:0] mmuKind;
        logic       fpu;
        logic       jext;
        logic       perf;
        logic       debug;
        logic       simd;
        logic       dsp;
        logic       rmw;
    } pcc_word0_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       rdStrobe;
        logic       wrStrobe;
    } pcc_req_type;

    function automatic pcc_word0_type pcc_make_word0(
        input logic [7:0] procId,
        input logic [3:0] procRev
    );
        pcc_word0_type w;
        w.procId   = procId;
        w.reserved = PCC_RSVD_VAL;
        w.procRev  = procRev;
        w.archType = PCC_ARCH_TYPE_VAL;
        w.archRev  = PCC_ARCH_REV_VAL;
        w.mmuKind  = PCC_MMU_SHARED;
        w.fpu      = PCC_FPU_VAL;
        w.jext     = PCC_JEXT_VAL;
        w.perf     = PCC_PERF_VAL;
        w.debug    = PCC_DEBUG_VAL;
        w.simd     = PCC_SIMD_VAL;
        w.dsp      = PCC_DSP_VAL;
        w.rmw      = PCC_RMW_VAL;
        return w;
    endfunction : pcc_make_word0

endpackage : pcc_pkg

/* pcc_word_rom.sv */
// constant capability words selected by address
`timescale 1ns/10ps
module pcc_word_rom
    import pcc_pkg::*;
#(
    parameter logic [7:0]  PROC_ID  = PCC_PROC_ID_DEF,
    parameter logic [3:0]  PROC_REV = PCC_PROC_REV_DEF,
    parameter logic [31:0] WORD1    = PCC_WORD1_DEF
)(
    input  wire logic [7:0]  addr,
    output logic      [31:0] word,
    output logic             hit
);

    pcc_word0_type word0;

    always_comb
    begin
        word0 = pcc_make_word0(PROC_ID, PROC_REV);
        word  = PCC_RDATA_ZERO;
        hit   = 1'b0;
        unique case (addr)
            PCC_ADDR_WORD0:
            begin
                word = word0;
                hit  = 1'b1;
            end
            PCC_ADDR_WORD1:
            begin
                word = WORD1;
                hit  = 1'b1;
            end
            default:
            begin
                word = PCC_RDATA_ZERO;
                hit  = 1'b0;
            end
        endcase
    end

endmodule : pcc_word_rom
